/* hw/ubr_pkg.sv */
/*
 * shared constants and types of the serial baud generator and pin setup.
 * assumes a single 25 MHz ref_clk and a plain one-cycle register port.
 */
`default_nettype none
package ubr_pkg;
	// register byte addresses
	localparam logic [15:0] ADR_PORT2_DIR = 16'hff22;
	localparam logic [15:0] ADR_PORT2_LATCH = 16'hff02;
	localparam logic [15:0] ADR_MODE = 16'hffa0;
	localparam logic [15:0] ADR_BAUD = 16'hffa2;
	localparam logic [15:0] ADR_STATUS = 16'hffa3;
	localparam logic [15:0] ADR_TX_DATA = 16'hffa4;
	localparam logic [15:0] ADR_RX_DATA = 16'hffa5;
	// values after reset
	localparam logic [7:0] DIR_RST = 8'hff;
	localparam logic [5:0] LATCH_RST = 6'h00;
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] BAUD_RST = 8'h00;
	// field positions
	localparam int MODE_TXE_BIT = 7;
	localparam int MODE_RXE_BIT = 6;
	localparam int MODE_IR_BIT = 0;
	localparam int BAUD_PS_LSB = 4;
	localparam int BAUD_DIV_LSB = 0;
	localparam int PIN_RX = 3;
	localparam int PIN_TX = 4;
	localparam int PIN_ECLK = 5;
	localparam int ST_TX_BUSY = 0;
	localparam int ST_RX_FULL = 1;
	localparam int ST_RX_OVR = 2;
	localparam int ST_TXF_EMPTY = 3;
	localparam int ST_TXF_READY = 4;
	// widths and counts
	localparam int P2_PINS = 6;
	localparam int PRE_W = 7;
	localparam int CNT_W = 5;
	localparam logic [4:0] DIV_BASE = 5'h10;
	localparam logic [3:0] DATA_BITS = 4'h8;
	localparam int TX_FIFO_DEPTH = 16;

	typedef enum logic [2:0] {
		TX_IDLE = 3'b001,
		TX_DATA = 3'b010,
		TX_STOP = 3'b100
	} ubr_tx_state_t;

	typedef enum logic [3:0] {
		RX_IDLE = 4'b0001,
		RX_START = 4'b0010,
		RX_DATA = 4'b0100,
		RX_STOP = 4'b1000
	} ubr_rx_state_t;

	// register bus request
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ubr_bus_req_t;

	// port-2 pin drive
	typedef struct packed {
		logic [P2_PINS-1:0] out;
		logic [P2_PINS-1:0] oe_n;
	} ubr_pins_t;
endpackage
`default_nettype wire

/* hw/ubr_top.sv */
/*
 * baud rate generator, port-2 pin setup, tx fifo and byte framing of the
 * asynchronous serial interface. assumes ref_clk at 25 MHz, a bus master
 * that issues one-cycle strobes, and pins resolved outside from oe_n.
 */
`default_nettype none

// tx data buffer: flip-flop storage addressed by read and write index
module ubr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} ubr_fifo_state_t;
	ubr_fifo_state_t s_q, s_d;
	logic push, pop;

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
		$error("ubr_fifo: depth must be a power of two, at least 2");
	end

	assign in_ready = (s_q.cnt != DEPTH[AW:0]);
	assign out_valid = (s_q.cnt != '0);
	assign out_data = s_q.mem[s_q.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// pointers wrap naturally because depth is a power of two
	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.wp] = in_data;
			s_d.wp = s_q.wp + 1'b1;
		end
		if (pop)
			s_d.rp = s_q.rp + 1'b1;
		if (push && !pop)
			s_d.cnt = s_q.cnt + 1'b1;
		else if (pop && !push)
			s_d.cnt = s_q.cnt - 1'b1;
	end

	always_ff @(posedge clk) begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end
endmodule

module ubr_top (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [15:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [7:0] bus_rdata,
	input wire logic [ubr_pkg::P2_PINS-1:0] port2_in,
	output logic [ubr_pkg::P2_PINS-1:0] port2_out,
	output logic [ubr_pkg::P2_PINS-1:0] port2_oe_n,
	output logic tx_fifo_ready,
	output logic baud_tick
);
	typedef struct packed {
		logic [7:0] dir;
		logic [5:0] latch;
		logic [7:0] mode;
		logic [7:0] baud;
		logic [7:0] rdata;
		logic [ubr_pkg::PRE_W-1:0] pre;
		logic [ubr_pkg::CNT_W-1:0] cnt;
		logic half;
		logic [ubr_pkg::P2_PINS-1:0] sync1;
		logic [ubr_pkg::P2_PINS-1:0] sync2;
		logic eclk_prev;
		ubr_pkg::ubr_tx_state_t tx_st;
		logic [7:0] tx_sh;
		logic [3:0] tx_bits;
		logic tx_line;
		ubr_pkg::ubr_rx_state_t rx_st;
		logic [7:0] rx_sh;
		logic [3:0] rx_bits;
		logic rx_ph;
		logic rx_prev;
		logic rx_low_seen;
		logic [7:0] rx_data;
		logic rx_full;
		logic rx_ovr;
		ubr_pkg::ubr_pins_t pins;
	} ubr_state_t;

	ubr_state_t s_q, s_d;
	ubr_pkg::ubr_bus_req_t req;
	logic txe, rxe, ir, running, src_tick, half_tick, bit_tick;
	logic rx_line, rx_bit, fifo_out_valid, fifo_pop, fifo_in_ready;
	logic [2:0] ps_sel;
	logic [3:0] div_sel;
	logic [4:0] div_top;
	logic [7:0] fifo_out_data;

	// prescaler tick for code n: low n bits of the free count all ones
	function automatic logic pre_tick(input logic [6:0] pre,
			input logic [2:0] n);
		logic [6:0] mask;
		mask = 7'h7f >> (3'h7 - n);
		return (pre & mask) == mask;
	endfunction

	// byte decode of a request, used by both the write and read paths
	function automatic logic hit(input ubr_pkg::ubr_bus_req_t r,
			input logic [15:0] a);
		return r.addr == a;
	endfunction

	assign req = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};
	assign txe = s_q.mode[ubr_pkg::MODE_TXE_BIT];
	assign rxe = s_q.mode[ubr_pkg::MODE_RXE_BIT];
	assign ir = s_q.mode[ubr_pkg::MODE_IR_BIT];
	assign running = txe || rxe;
	assign ps_sel = s_q.baud[ubr_pkg::BAUD_PS_LSB +: 3];
	assign div_sel = s_q.baud[ubr_pkg::BAUD_DIV_LSB +: 4];
	assign div_top = ubr_pkg::DIV_BASE + {1'b0, div_sel} - 5'h01;

	// source select: synced pin edge for code 0, else main clock / 2^n
	assign src_tick = (ps_sel == 3'h0) ?
		(s_q.sync2[ubr_pkg::PIN_ECLK] && !s_q.eclk_prev) :
		pre_tick(s_q.pre, ps_sel);
	assign half_tick = running && src_tick && (s_q.cnt == div_top);
	// the final halving gives the 2^(n+1) term of the bit rate
	assign bit_tick = half_tick && s_q.half;
	assign baud_tick = bit_tick;

	// infrared receive: a high pulse on the line marks a zero bit
	assign rx_line = ir ? !s_q.sync2[ubr_pkg::PIN_RX] :
		s_q.sync2[ubr_pkg::PIN_RX];
	assign rx_bit = ir ? !s_q.rx_low_seen : rx_line;

	assign fifo_pop = txe && bit_tick && (s_q.tx_st != ubr_pkg::TX_DATA) &&
		fifo_out_valid;
	assign tx_fifo_ready = fifo_in_ready;
	assign bus_rdata = s_q.rdata;
	assign port2_out = s_q.pins.out;
	assign port2_oe_n = s_q.pins.oe_n;

	ubr_fifo #(
		.WIDTH(8),
		.DEPTH(ubr_pkg::TX_FIFO_DEPTH)
	) u_tx_fifo (
		.clk(ref_clk),
		.rst(sys_rst),
		.in_valid(req.wr && hit(req, ubr_pkg::ADR_TX_DATA)),
		.in_ready(fifo_in_ready),
		.in_data(req.wdata),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data)
	);

	// next state of registers, divider chain, framing and pins
	always_comb begin
		s_d = s_q;
		s_d.sync1 = port2_in;
		s_d.sync2 = s_q.sync1;
		s_d.eclk_prev = s_q.sync2[ubr_pkg::PIN_ECLK];

		// register writes; a prohibited divisor is stored as written
		if (req.wr) begin
			if (hit(req, ubr_pkg::ADR_PORT2_DIR))
				s_d.dir = {2'b11, req.wdata[5:0]};
			if (hit(req, ubr_pkg::ADR_PORT2_LATCH))
				s_d.latch = req.wdata[5:0];
			if (hit(req, ubr_pkg::ADR_MODE))
				s_d.mode = req.wdata;
			if (hit(req, ubr_pkg::ADR_BAUD))
				s_d.baud = {1'b0, req.wdata[6:0]};
		end

		// read data stands the cycle after the strobe; unmapped reads zero
		s_d.rdata = 8'h00;
		if (req.rd) begin
			case (1'b1)
				hit(req, ubr_pkg::ADR_PORT2_DIR): s_d.rdata = s_q.dir;
				hit(req, ubr_pkg::ADR_PORT2_LATCH): s_d.rdata = {2'b00, s_q.latch};
				hit(req, ubr_pkg::ADR_MODE): s_d.rdata = s_q.mode;
				hit(req, ubr_pkg::ADR_BAUD): s_d.rdata = s_q.baud;
				hit(req, ubr_pkg::ADR_RX_DATA): s_d.rdata = s_q.rx_data;
				hit(req, ubr_pkg::ADR_STATUS): begin
					s_d.rdata[ubr_pkg::ST_TX_BUSY] = (s_q.tx_st != ubr_pkg::TX_IDLE);
					s_d.rdata[ubr_pkg::ST_RX_FULL] = s_q.rx_full;
					s_d.rdata[ubr_pkg::ST_RX_OVR] = s_q.rx_ovr;
					s_d.rdata[ubr_pkg::ST_TXF_EMPTY] = !fifo_out_valid;
					s_d.rdata[ubr_pkg::ST_TXF_READY] = fifo_in_ready;
				end
				default: s_d.rdata = 8'h00;
			endcase
			// reading the byte frees the holding register
			if (hit(req, ubr_pkg::ADR_RX_DATA)) begin
				s_d.rx_full = 1'b0;
				s_d.rx_ovr = 1'b0;
			end
		end

		// divider chain only runs outside operation stop
		if (!running) begin
			s_d.pre = '0;
			s_d.cnt = '0;
			s_d.half = 1'b0;
		end else begin
			s_d.pre = s_q.pre + 1'b1;
			if (src_tick)
				s_d.cnt = half_tick ? '0 : s_q.cnt + 1'b1;
			if (half_tick)
				s_d.half = !s_q.half;
		end

		// transmitter: start, eight data bits lsb first, one stop bit
		if (!txe) begin
			s_d.tx_st = ubr_pkg::TX_IDLE;
			s_d.tx_line = 1'b1;
		end else if (bit_tick) begin
			case (s_q.tx_st)
				ubr_pkg::TX_IDLE, ubr_pkg::TX_STOP: begin
					s_d.tx_st = ubr_pkg::TX_IDLE;
					s_d.tx_line = 1'b1;
					if (fifo_out_valid) begin
						s_d.tx_sh = fifo_out_data;
						s_d.tx_bits = 4'h0;
						s_d.tx_line = 1'b0;
						s_d.tx_st = ubr_pkg::TX_DATA;
					end
				end
				ubr_pkg::TX_DATA: begin
					if (s_q.tx_bits == ubr_pkg::DATA_BITS) begin
						s_d.tx_line = 1'b1;
						s_d.tx_st = ubr_pkg::TX_STOP;
					end else begin
						s_d.tx_line = s_q.tx_sh[0];
						s_d.tx_sh = {1'b0, s_q.tx_sh[7:1]};
						s_d.tx_bits = s_q.tx_bits + 4'h1;
					end
				end
				default: s_d.tx_st = ubr_pkg::TX_IDLE;
			endcase
		end

		// receiver: half-bit steps; runs beside the transmitter
		s_d.rx_prev = rx_line;
		if (!rx_line)
			s_d.rx_low_seen = 1'b1;
		if (!rxe) begin
			s_d.rx_st = ubr_pkg::RX_IDLE;
		end else begin
			case (s_q.rx_st)
				ubr_pkg::RX_IDLE:
					if (s_q.rx_prev && !rx_line)
						s_d.rx_st = ubr_pkg::RX_START;
				ubr_pkg::RX_START:
					if (half_tick) begin
						s_d.rx_st = rx_line && !ir ? ubr_pkg::RX_IDLE :
							ubr_pkg::RX_DATA;
						s_d.rx_ph = 1'b0;
						s_d.rx_bits = 4'h0;
						s_d.rx_low_seen = !rx_line;
					end
				ubr_pkg::RX_DATA:
					if (half_tick) begin
						s_d.rx_ph = !s_q.rx_ph;
						if (s_q.rx_ph) begin
							s_d.rx_sh = {rx_bit, s_q.rx_sh[7:1]};
							s_d.rx_bits = s_q.rx_bits + 4'h1;
							s_d.rx_low_seen = !rx_line;
							if (s_q.rx_bits == ubr_pkg::DATA_BITS - 4'h1)
								s_d.rx_st = ubr_pkg::RX_STOP;
						end
					end
				ubr_pkg::RX_STOP:
					if (half_tick) begin
						s_d.rx_ph = !s_q.rx_ph;
						if (s_q.rx_ph) begin
							s_d.rx_st = ubr_pkg::RX_IDLE;
							// a bad stop bit drops the byte
							if (rx_bit) begin
								s_d.rx_data = s_q.rx_sh;
								s_d.rx_full = 1'b1; // set wins over read
								s_d.rx_ovr = s_q.rx_full || s_q.rx_ovr;
							end
						end
					end
				default: s_d.rx_st = ubr_pkg::RX_IDLE;
			endcase
		end

		// port pins: direction bits steer the buffers, latch the level
		s_d.pins.oe_n = s_q.dir[ubr_pkg::P2_PINS-1:0];
		s_d.pins.out = s_q.latch;
		if (txe) begin
			// infrared zero: high pulse in the first half of the bit
			s_d.pins.out[ubr_pkg::PIN_TX] = ir ?
				(!s_q.tx_line && !s_q.half) : s_q.tx_line;
		end
		// never fight the remote end on a pin taken for receive
		if (rxe)
			s_d.pins.oe_n[ubr_pkg::PIN_RX] = 1'b1;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.dir <= ubr_pkg::DIR_RST;
			s_q.latch <= ubr_pkg::LATCH_RST;
			s_q.mode <= ubr_pkg::MODE_RST;
			s_q.baud <= ubr_pkg::BAUD_RST;
			s_q.tx_st <= ubr_pkg::TX_IDLE;
			s_q.tx_line <= 1'b1;
			s_q.rx_st <= ubr_pkg::RX_IDLE;
			s_q.rx_prev <= 1'b1;
			s_q.pins.oe_n <= '1;
		end else begin
			s_q <= s_d;
		end
	end
endmodule
`default_nettype wire

/* sim/ubr_top_assertions.sv */
/* assertion checker for ubr_top, bound to its ports.
   assumes one clock; register writes take effect at the strobe edge. */
`default_nettype none
module ubr_chk (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [15:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_rdata,
	input wire logic [5:0] port2_in,
	input wire logic [5:0] port2_out,
	input wire logic [5:0] port2_oe_n,
	input wire logic tx_fifo_ready,
	input wire logic baud_tick
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] dir_q, mode_q, baud_q;
	logic [15:0] cnt_q, per;
	logic ok_q, w_dir, w_mode, w_baud;
	// shadow copies of the direction, mode and baud registers
	assign w_dir = bus_wr && bus_addr == ubr_pkg::ADR_PORT2_DIR;
	assign w_mode = bus_wr && bus_addr == ubr_pkg::ADR_MODE;
	assign w_baud = bus_wr && bus_addr == ubr_pkg::ADR_BAUD;
	assign per = (16'(baud_q[3:0]) + 16'h0010) << ({1'b0, baud_q[6:4]} + 4'h1);
	// ok_q waits one tick after any reconfiguration, whose phase is free
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			dir_q <= 8'hff;
			mode_q <= 8'h00;
			baud_q <= 8'h00;
			cnt_q <= 16'h0000;
			ok_q <= 1'b0;
		end else begin
			dir_q <= w_dir ? bus_wdata : dir_q;
			mode_q <= w_mode ? bus_wdata : mode_q;
			baud_q <= w_baud ? bus_wdata : baud_q;
			cnt_q <= baud_tick ? 16'h0000 : cnt_q + 16'h0001;
			ok_q <= (w_mode || w_baud) ? 1'b0 : (ok_q || baud_tick);
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	property p_rst_pins;
		disable iff (1'b0) sys_rst |=> port2_oe_n == 6'h3f && !baud_tick;
	endproperty
	a_rst_pins: assert property (p_rst_pins)
		else $error("pins not inputs after reset");
	property p_rd_dir;
		bus_rd && bus_addr == ubr_pkg::ADR_PORT2_DIR
			|=> bus_rdata == (dir_q | 8'hc0);
	endproperty
	a_rd_dir: assert property (p_rd_dir)
		else $error("direction readback wrong");
	property p_rd_baud;
		bus_rd && bus_addr == ubr_pkg::ADR_BAUD |=> bus_rdata == {1'b0, baud_q[6:0]};
	endproperty
	a_rd_baud: assert property (p_rd_baud)
		else $error("baud readback wrong");
	property p_stop_quiet;
		mode_q[7:6] == 2'b00 [*2] |-> !baud_tick;
	endproperty
	a_stop_quiet: assert property (p_stop_quiet)
		else $error("tick while stopped");
	property p_stop_pins;
		(!bus_wr [*3]) ##0 mode_q[7:6] == 2'b00 |-> port2_oe_n == dir_q[5:0];
	endproperty
	a_stop_pins: assert property (p_stop_pins)
		else $error("pin enables differ from direction");
	property p_rx_pin;
		mode_q[6] [*3] |-> port2_oe_n[3];
	endproperty
	a_rx_pin: assert property (p_rx_pin)
		else $error("receive pin driven");
	property p_tick_gap;
		baud_tick && ok_q && mode_q[7:6] != 2'b00 && baud_q[6:4] != 3'h0
			|-> cnt_q == per - 16'h0001;
	endproperty
	a_tick_gap: assert property (p_tick_gap)
		else $error("bit period wrong");
	property p_tick_one;
		baud_tick |=> !baud_tick;
	endproperty
	a_tick_one: assert property (p_tick_one)
		else $error("tick longer than one cycle");
endmodule
bind ubr_top ubr_chk ubr_chk_i (
	.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
	.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
	.bus_rdata(bus_rdata), .port2_in(port2_in), .port2_out(port2_out),
	.port2_oe_n(port2_oe_n), .tx_fifo_ready(tx_fifo_ready),
	.baud_tick(baud_tick)
);
`default_nettype wire

/* sim/ubr_remote.sv */
/* remote serial device on the tx and rx lines: counts good frames and
   sends one byte on request. assumes a fixed bit time in ref_clk cycles. */
`default_nettype none
module ubr_remote #(
	parameter int BIT = 64
) (
	input wire logic ref_clk,
	input wire logic tx_line,
	input wire logic [7:0] send_byte,
	input wire logic send_go,
	output logic rx_line,
	output logic [7:0] got_byte,
	output int got_count
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [9:0] frame;
	initial begin
		rx_line = 1'b1;
		got_byte = 8'h00;
		got_count = 0;
	end
	// receiver: recheck start mid-bit so a glitch is not taken as a frame
	always begin
		@(negedge tx_line);
		repeat (BIT / 2) @(posedge ref_clk);
		if (tx_line === 1'b0) begin
			for (int i = 0; i < 8; i++) begin
				repeat (BIT) @(posedge ref_clk);
				got_byte[i] = tx_line; // lsb first
			end
			repeat (BIT) @(posedge ref_clk);
			if (tx_line === 1'b1) begin
				got_count++; // one stop bit
			end
		end
	end
	// sender: start low, byte lsb first, stop high, then idle high
	always begin
		@(posedge ref_clk);
		if (send_go === 1'b1) begin
			frame = {1'b1, send_byte, 1'b0};
			for (int i = 0; i < 10; i++) begin
				rx_line <= frame[i];
				repeat (BIT) @(posedge ref_clk);
			end
		end
	end
endmodule
`default_nettype wire

/* sim/ubr_top_tb.sv */
/* self-checking bench for ubr_top: register tasks, bit period runs,
   a duplex exchange and a fifo fill. assumes ubr_remote at the pins. */
`default_nettype none
module ubr_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic eclk = 1'b0;
	logic go = 1'b0;
	logic [15:0] bus_addr = 16'h0000;
	logic [7:0] bus_wdata = 8'h00;
	logic [7:0] bus_rdata, got;
	logic [5:0] pin, drv, p_out, p_oe_n, oe_snap, out_snap;
	logic rdy, tick, rx_line, pin_prev;
	logic [7:0] dv [2] = '{8'h15, 8'h2a};
	logic [2:0] pn [5] = '{3'h0, 3'h1, 3'h7, 3'h3, 3'h5};
	logic [3:0] pk [5] = '{4'h2, 4'h0, 4'he, 4'h5, 4'h9};
	int err_count = 0;
	int tests_run = 0;
	int got_count, n_push, n_pulse;
	initial begin
		forever #20 ref_clk = ~ref_clk;
	end
	// external baud clock, eight ref_clk cycles a period
	always begin
		repeat (4) @(posedge ref_clk);
		eclk <= ~eclk;
	end
	// released lines rest high through pull-ups, except pin 3 (remote rx_line) and pin 5 (eclk)
	assign drv = {eclk, 1'b1, rx_line, 3'b111};
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			pin[i] = p_oe_n[i] ? drv[i] : p_out[i];
		end
	end
	ubr_top ubr_top_i (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_rdata(bus_rdata), .port2_in(pin), .port2_out(p_out),
		.port2_oe_n(p_oe_n), .tx_fifo_ready(rdy), .baud_tick(tick)
	);
	ubr_remote #(.BIT(64)) ubr_remote_i (
		.ref_clk(ref_clk), .tx_line(pin[4]), .send_byte(8'h3c),
		.send_go(go), .rx_line(rx_line), .got_byte(got),
		.got_count(got_count)
	);
	task automatic check(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// strobes drop with a free cycle after, so no edge sees two drives
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge ref_clk);
		bus_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge ref_clk);
		bus_rd <= 1'b0;
		@(negedge ref_clk);
		oe_snap = p_oe_n;
		out_snap = p_out;
		check({8'h00, bus_rdata}, {8'h00, e});
		@(posedge ref_clk);
	endtask
	task automatic wait_tick(output int c);
		c = 0;
		do begin
			@(negedge ref_clk);
			c++;
		end while (tick !== 1'b1 && c < 20000);
		if (c >= 20000) begin
			err_count++;
			final_report();
		end
	endtask
	task automatic period(input logic [2:0] n, input logic [3:0] k);
		int c;
		logic [15:0] e;
		e = (16'(k) + 16'h0010) << (n + 4'h1);
		if (n == 3'h0) begin
			e = e << 3;
		end
		wr(ubr_pkg::ADR_BAUD, {1'b0, n, k});
		wr(ubr_pkg::ADR_MODE, 8'h40);
		wait_tick(c);
		wait_tick(c);
		check(16'(c), e);
		@(posedge ref_clk);
		wr(ubr_pkg::ADR_MODE, 8'h00);
	endtask
	task automatic final_report();
		$display("checks %0d, errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		rd(ubr_pkg::ADR_PORT2_DIR, 8'hff);
		rd(ubr_pkg::ADR_MODE, 8'h00);
		rd(ubr_pkg::ADR_BAUD, 8'h00);
		rd(16'h1234, 8'h00);
		// top divisor software may use; bit 7 is not stored
		wr(ubr_pkg::ADR_BAUD, 8'hfe);
		rd(ubr_pkg::ADR_BAUD, 8'h7e);
		for (int i = 0; i < 2; i++) begin
			wr(ubr_pkg::ADR_PORT2_DIR, dv[i]);
			rd(ubr_pkg::ADR_PORT2_DIR, dv[i] | 8'hc0);
			check({10'h000, oe_snap}, {10'h000, dv[i][5:0]});
		end
		// stopped pins show the port latch; bit 4 stays clear for tx use
		wr(ubr_pkg::ADR_PORT2_LATCH, 8'hea);
		rd(ubr_pkg::ADR_PORT2_LATCH, 8'h2a);
		check({10'h000, out_snap}, 16'h002a);
		for (int i = 0; i < 5; i++) begin
			period(pn[i], pk[i]);
		end
		// tx idles high before its pin is turned to output
		wr(ubr_pkg::ADR_BAUD, 8'h10);
		wr(ubr_pkg::ADR_MODE, 8'hc0);
		wr(ubr_pkg::ADR_PORT2_DIR, 8'hef);
		go <= 1'b1;
		wr(ubr_pkg::ADR_TX_DATA, 8'ha5);
		go <= 1'b0;
		n_push = 1;
		while (rdy === 1'b1 && n_push < 40) begin
			wr(ubr_pkg::ADR_TX_DATA, 8'h5a);
			n_push++;
		end
		check({15'h0000, rdy}, 16'h0000);
		wr(ubr_pkg::ADR_TX_DATA, 8'hff);
		for (int i = 0; i < 30000 && got_count < n_push; i++) begin
			@(posedge ref_clk);
		end
		repeat (800) @(posedge ref_clk);
		check(16'(got_count), 16'(n_push));
		check({8'h00, got}, 16'h005a);
		rd(ubr_pkg::ADR_RX_DATA, 8'h3c);
		// infrared transmit only: one high pulse per zero bit, idle low
		wr(ubr_pkg::ADR_MODE, 8'h00);
		wr(ubr_pkg::ADR_BAUD, 8'h10);
		wr(ubr_pkg::ADR_MODE, 8'h81);
		wr(ubr_pkg::ADR_TX_DATA, 8'h0f);
		n_pulse = 0;
		pin_prev = pin[4];
		for (int i = 0; i < 900; i++) begin
			@(negedge ref_clk);
			if (pin[4] && !pin_prev) begin
				n_pulse++;
			end
			pin_prev = pin[4];
		end
		// start bit plus four zero data bits of 0f
		check(16'(n_pulse), 16'h0005);
		@(posedge ref_clk);
		// reset in mid-run must bring direction, pins, mode, baud, latch and status back
		sys_rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		rd(ubr_pkg::ADR_PORT2_DIR, 8'hff);
		check({10'h000, oe_snap}, 16'h003f);
		check({10'h000, out_snap}, 16'h0000);
		rd(ubr_pkg::ADR_MODE, 8'h00);
		rd(ubr_pkg::ADR_BAUD, 8'h00);
		rd(ubr_pkg::ADR_PORT2_LATCH, 8'h00);
		rd(ubr_pkg::ADR_STATUS, 8'h18);
		final_report();
	end
endmodule
`default_nettype wire
